// *** hw/ssc_regs.vh ***
// register map, field positions and reset values of the switch scan configuration block
`ifndef SSC_REGS_VH
`define SSC_REGS_VH

// ==========================================================
// register byte offsets
`define SSC_OFS_GLOBAL   8'h00
`define SSC_OFS_GRID     8'h04
`define SSC_OFS_IN_EN    8'h08
`define SSC_OFS_MODE     8'h0C
`define SSC_OFS_CS_SEL   8'h10
`define SSC_OFS_WET_A    8'h14
`define SSC_OFS_WET_B    8'h18
`define SSC_OFS_CCS_TIM  8'h1C
`define SSC_OFS_CCS_IN   8'h20
`define SSC_OFS_CTRL     8'h24
`define SSC_OFS_STATUS   8'h28
`define SSC_OFS_SCALE    8'h2C

// ==========================================================
// bus encodings
`define SSC_HSIZE_WORD   3'h2

// ==========================================================
// reset values
`define SSC_RST_32       32'h0000_0000
`define SSC_RST_24       24'h00_0000
`define SSC_RST_5        5'h00
`define SSC_RST_2        2'h0

// ==========================================================
// global setup fields
`define SSC_G_PERIOD_HI  4
`define SSC_G_PERIOD_LO  1
`define SSC_G_ACT_HI     8
`define SSC_G_ACT_LO     5
`define SSC_G_SUPPLY     16
`define SSC_G_DIAG_HI    21
`define SSC_G_DIAG_LO    18

// ==========================================================
// grid register fields and codes
`define SSC_GR_MODE_HI   4
`define SSC_GR_MODE_LO   3
`define SSC_GR_WIN_HI    2
`define SSC_GR_WIN_LO    0
`define SSC_GRID_OFF     2'h0
`define SSC_GRID_4X4     2'h1
`define SSC_GRID_5X5     2'h2
`define SSC_GRID_6X6     2'h3
`define SSC_SNK_BASE     4
`define SSC_SRC_BASE     10

// ==========================================================
// wetting fields
`define SSC_WB_AS_HI     22
`define SSC_WB_AS_LO     21
`define SSC_AS_OFF       2'h3
`define SSC_WA_SRC_LO    6
`define SSC_WA_SNK_LO    18
`define SSC_WB_SNK_LO    0
`define SSC_CODE_1MA     3'h1
`define SSC_CODE_2MA     3'h2
`define SSC_CODE_5MA     3'h3
`define SSC_CODE_MSB     2
`define SSC_N_GROUPS     14

// ==========================================================
// control register bits
`define SSC_C_POLL       0
`define SSC_C_TW         1

// ==========================================================
// diagnostic input settings
`define SSC_ADC_ALL      4'hF
`define SSC_SRC_PAIR     2'h0
`define SSC_SNK_PAIR     2'h3

`endif

// *** hw/ssc_check.v ***
// configuration legality checker for grid, pairing, thermal and diagnostic settings
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.vh"

module ssc_check (
  // configuration
  input  wire        poll_en,
  input  wire        tw_expected,
  input  wire [1:0]  grid_mode,
  input  wire [23:0] in_en,
  input  wire [23:0] in_mode,
  input  wire [23:0] cs_sel,
  input  wire [23:0] wet_a,
  input  wire [23:0] wet_b,
  input  wire [3:0]  diag_sel,
  // verdicts
  output wire        grid_ok,
  output wire        pair_ok,
  output wire        thermal_ok,
  output wire        diag_ok
);

  // mask of grid rows in use, one bit per line from input 4 or 10 upward
  function [5:0] grid_mask;
    input [1:0] gm;
    begin
      case (gm)
        `SSC_GRID_4X4: grid_mask = 6'h0F;
        `SSC_GRID_5X5: grid_mask = 6'h1F;
        `SSC_GRID_6X6: grid_mask = 6'h3F;
        default:       grid_mask = 6'h00;
      endcase
    end
  endfunction

  // all masked bits set
  function all_set;
    input [5:0] v;
    input [5:0] m;
    begin
      all_set = ((v & m) == m);
    end
  endfunction

  wire [5:0] m = grid_mask(grid_mode);
  wire       grid_on = (grid_mode != `SSC_GRID_OFF);

  // sinks on the low grid lines, sources on the high ones, all comparators, sampling periodic
  assign grid_ok = !grid_on || (poll_en
                   && all_set(in_en[`SSC_SNK_BASE +: 6], m)
                   && all_set(in_en[`SSC_SRC_BASE +: 6], m)
                   && ((in_mode[`SSC_SNK_BASE +: 6] & m) == 6'h00)
                   && ((in_mode[`SSC_SRC_BASE +: 6] & m) == 6'h00)
                   && all_set(cs_sel[`SSC_SNK_BASE +: 6], m)
                   && ((cs_sel[`SSC_SRC_BASE +: 6] & m) == 6'h00));

  // sink and source codes of the four wetting pairs
  wire [11:0] snk = {wet_b[`SSC_WB_SNK_LO +: 6], wet_a[`SSC_WA_SNK_LO +: 6]};
  wire [11:0] src = wet_a[`SSC_WA_SRC_LO +: 12];
  wire [3:0]  need = (grid_mode == `SSC_GRID_4X4) ? 4'h7 : (grid_on ? 4'hF : 4'h0);
  wire [3:0]  gt_ok;
  wire [3:0]  tw_ok;

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_pair
      assign gt_ok[k] = snk[3*k +: 3] > src[3*k +: 3];
      assign tw_ok[k] = ((src[3*k +: 3] == `SSC_CODE_1MA)
                         && (snk[3*k +: 3] >= `SSC_CODE_2MA))
                     || ((src[3*k +: 3] == `SSC_CODE_2MA)
                         && (snk[3*k +: 3] == `SSC_CODE_5MA));
    end
  endgenerate

  assign pair_ok    = ((gt_ok | ~need) == 4'hF);
  assign thermal_ok = !tw_expected || ((tw_ok | ~need) == 4'hF);

  // diagnostics: any of 0..3 on, all ADC, 0/1 source, 2/3 sink
  assign diag_ok = (diag_sel == 4'h0) || ((in_en[3:0] != 4'h0)
                   && (in_mode[3:0] == `SSC_ADC_ALL)
                   && (cs_sel[1:0] == `SSC_SRC_PAIR)
                   && (cs_sel[3:2] == `SSC_SNK_PAIR));

endmodule
`default_nettype wire

// *** hw/ssc_top.v ***
// switch scan configuration registers with ahb-lite slave and effective-feature logic
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.vh"

module ssc_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // effective scan settings
  output reg  [3:0]  poll_period_code,
  output reg  [3:0]  active_window_code,
  output reg  [2:0]  grid_window_code,
  output reg  [1:0]  grid_mode,
  output reg         poll_enable,
  output reg         clean_sampling_active,
  output reg  [13:0] autoscale_group,
  output reg         config_legal
);

  // ==========================================================
  // register storage
  reg [31:0] global_r;
  reg [4:0]  grid_r;
  reg [23:0] in_en_r;
  reg [23:0] mode_r;
  reg [23:0] cs_sel_r;
  reg [23:0] wetting_level_cfg_a_r;
  reg [23:0] wetting_level_cfg_b_r;
  reg [31:0] clean_sampling_timing_cfg_r;
  reg [23:0] clean_sampling_input_cfg_r;
  reg [1:0]  ctrl_r;

  // ==========================================================
  // bus phase tracking
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg [7:0]  addr_r;

  wire take = hsel && htrans[1] && hready;
  wire wr_go = wr_pend_r;

  // only whole-word accesses change state; narrower writes are dropped
  reg        wr_word_r;

  // address phase capture; reads stall one cycle so they see any write just completed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_word_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        addr_r    <= haddr;
        wr_word_r <= (hsize == `SSC_HSIZE_WORD);
      end
    end
  end

  // ==========================================================
  // legality checker
  wire grid_ok;
  wire pair_ok;
  wire thermal_ok;
  wire diag_ok;

  ssc_check u_check (
    .poll_en     (ctrl_r[`SSC_C_POLL]),
    .tw_expected (ctrl_r[`SSC_C_TW]),
    .grid_mode   (grid_r[`SSC_GR_MODE_HI:`SSC_GR_MODE_LO]),
    .in_en       (in_en_r),
    .in_mode     (mode_r),
    .cs_sel      (cs_sel_r),
    .wet_a       (wetting_level_cfg_a_r),
    .wet_b       (wetting_level_cfg_b_r),
    .diag_sel    (global_r[`SSC_G_DIAG_HI:`SSC_G_DIAG_LO]),
    .grid_ok     (grid_ok),
    .pair_ok     (pair_ok),
    .thermal_ok  (thermal_ok),
    .diag_ok     (diag_ok)
  );

  // ==========================================================
  // effective features
  // clean sampling needs something being measured to ride on
  wire clean_nxt = (clean_sampling_input_cfg_r != 24'h00_0000)
                && ((in_en_r != 24'h00_0000) || global_r[`SSC_G_SUPPLY]);
  wire as_on = (wetting_level_cfg_b_r[`SSC_WB_AS_HI:`SSC_WB_AS_LO] != `SSC_AS_OFF)
            && !ctrl_r[`SSC_C_POLL];
  wire [41:0] codes = {wetting_level_cfg_b_r[17:0], wetting_level_cfg_a_r};
  wire [13:0] scale_nxt;

  genvar g;
  generate
    for (g = 0; g < `SSC_N_GROUPS; g = g + 1) begin : g_scale
      // only codes 4 to 7, the four highest currents, are scaled back
      assign scale_nxt[g] = as_on && codes[3*g + `SSC_CODE_MSB];
    end
  endgenerate

  wire legal_nxt = grid_ok && pair_ok && thermal_ok && diag_ok;
  wire [31:0] status_w = {26'h000_0000, as_on, clean_nxt, diag_ok, thermal_ok,
                          pair_ok, grid_ok};

  // ==========================================================
  // read mux, unmapped offsets read zero
  function [31:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `SSC_OFS_GLOBAL:  rd_mux = global_r;
        `SSC_OFS_GRID:    rd_mux = {27'h000_0000, grid_r};
        `SSC_OFS_IN_EN:   rd_mux = {8'h00, in_en_r};
        `SSC_OFS_MODE:    rd_mux = {8'h00, mode_r};
        `SSC_OFS_CS_SEL:  rd_mux = {8'h00, cs_sel_r};
        `SSC_OFS_WET_A:   rd_mux = {8'h00, wetting_level_cfg_a_r};
        `SSC_OFS_WET_B:   rd_mux = {8'h00, wetting_level_cfg_b_r};
        `SSC_OFS_CCS_TIM: rd_mux = clean_sampling_timing_cfg_r;
        `SSC_OFS_CCS_IN:  rd_mux = {8'h00, clean_sampling_input_cfg_r};
        `SSC_OFS_CTRL:    rd_mux = {30'h0000_0000, ctrl_r};
        `SSC_OFS_STATUS:  rd_mux = status_w;
        `SSC_OFS_SCALE:   rd_mux = {18'h0_0000, scale_nxt};
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  // ==========================================================
  // register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_r                    <= `SSC_RST_32;
      grid_r                      <= `SSC_RST_5;
      in_en_r                     <= `SSC_RST_24;
      mode_r                      <= `SSC_RST_24;
      cs_sel_r                    <= `SSC_RST_24;
      wetting_level_cfg_a_r       <= `SSC_RST_24;
      wetting_level_cfg_b_r       <= `SSC_RST_24;
      clean_sampling_timing_cfg_r <= `SSC_RST_32;
      clean_sampling_input_cfg_r  <= `SSC_RST_24;
      ctrl_r                      <= `SSC_RST_2;
    end else if (wr_go && wr_word_r) begin
      case (addr_r)
        `SSC_OFS_GLOBAL:  global_r                    <= hwdata;
        `SSC_OFS_GRID:    grid_r                      <= hwdata[4:0];
        `SSC_OFS_IN_EN:   in_en_r                     <= hwdata[23:0];
        `SSC_OFS_MODE:    mode_r                      <= hwdata[23:0];
        `SSC_OFS_CS_SEL:  cs_sel_r                    <= hwdata[23:0];
        `SSC_OFS_WET_A:   wetting_level_cfg_a_r       <= hwdata[23:0];
        `SSC_OFS_WET_B:   wetting_level_cfg_b_r       <= hwdata[23:0];
        `SSC_OFS_CCS_TIM: clean_sampling_timing_cfg_r <= hwdata;
        `SSC_OFS_CCS_IN:  clean_sampling_input_cfg_r  <= hwdata[23:0];
        `SSC_OFS_CTRL:    ctrl_r                      <= hwdata[1:0];
        default:          ctrl_r                      <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // bus answer: writes zero-wait, reads one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_r) begin
        hrdata    <= rd_mux(addr_r);
        hreadyout <= 1'b1;
      end
    end
  end

  // ==========================================================
  // effective setting outputs, one cycle behind the registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poll_period_code      <= 4'h0;
      active_window_code    <= 4'h0;
      grid_window_code      <= 3'h0;
      grid_mode             <= 2'h0;
      poll_enable           <= 1'b0;
      clean_sampling_active <= 1'b0;
      autoscale_group       <= 14'h0000;
      config_legal          <= 1'b1;
    end else begin
      poll_period_code      <= global_r[`SSC_G_PERIOD_HI:`SSC_G_PERIOD_LO];
      active_window_code    <= global_r[`SSC_G_ACT_HI:`SSC_G_ACT_LO];
      grid_window_code      <= grid_r[`SSC_GR_WIN_HI:`SSC_GR_WIN_LO];
      grid_mode             <= grid_r[`SSC_GR_MODE_HI:`SSC_GR_MODE_LO];
      poll_enable           <= ctrl_r[`SSC_C_POLL];
      clean_sampling_active <= clean_nxt;
      autoscale_group       <= scale_nxt;
      config_legal          <= legal_nxt;
    end
  end

endmodule
`default_nettype wire

// *** test/ssc_top_asserts.sv ***
// concurrent checks on the ports of the switch scan configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.vh"
module ssc_chk (
  // bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // settings
  input wire logic [3:0]  poll_period_code,
  input wire logic [1:0]  grid_mode,
  input wire logic        poll_enable,
  input wire logic [13:0] autoscale_group,
  input wire logic        clean_sampling_active,
  input wire logic        config_legal
);
  // ==========================================================
  // helper state
  logic       rd;
  logic       wr;
  logic [3:0] wr_d_r;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign wr = hsel && htrans[1] && hready && hwrite;
  // write history; settings only move a few edges after a write lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_d_r <= 4'h0;
    else
      wr_d_r <= {wr_d_r[2:0], wr};
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // bus answer
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr |=> hreadyout)
    else $error("write stalled");
  a_wait_cause: assert property (!hreadyout |-> $past(rd))
    else $error("wait state without read");
  // ==========================================================
  // settings follow writes only
  a_period_move: assert property (!$stable(poll_period_code) |-> |wr_d_r[3:1])
    else $error("period code moved without write");
  a_grid_move: assert property ($changed(grid_mode) |-> |wr_d_r[3:1])
    else $error("grid mode moved without write");
  a_legal_move: assert property ($rose(config_legal) || $fell(config_legal) |-> |wr_d_r[3:1])
    else $error("legal flag moved without write");
  a_poll_follows: assert property (
    wr && haddr == `SSC_OFS_CTRL && hsize == 3'h2 |=> ##2 poll_enable == $past(hwdata[0], 2))
    else $error("poll enable not taken from control write");
  a_scale_cont: assert property (autoscale_group != 14'h0 |-> !poll_enable)
    else $error("autoscale active while polling");
  c_read: cover property (rd ##2 hreadyout);
  c_scale: cover property (autoscale_group != 14'h0);
  c_illegal: cover property ($fell(config_legal));
  c_clean: cover property (clean_sampling_active);
endmodule
bind ssc_top ssc_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .poll_period_code(poll_period_code),
  .grid_mode(grid_mode), .poll_enable(poll_enable), .autoscale_group(autoscale_group),
  .clean_sampling_active(clean_sampling_active), .config_legal(config_legal)
);
`default_nettype wire

// *** test/ssc_host.sv ***
// bus master model standing in for the configuring microcontroller
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
  // clock
  input  wire logic        hclk,
  // master side
  output var  logic        hsel,
  output var  logic [7:0]  haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // idle bus at time zero; only whole words are ever sent
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single transfer, entered just after a rising edge; the caller
  // reprograms rather than trusting the device, so every write is whole
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d : ~d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // released data lines must not keep looking valid
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** test/test_switch_scan_config_constraints.sv ***
// self-checking bench for the switch scan configuration block
`timescale 1ns/1ps
`default_nettype none
module test_switch_scan_config_constraints;
  // ==========================================================
  // wiring and tables
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  wire logic         hsel, hwrite, hreadyout, hresp, poll_enable;
  wire logic         clean_sampling_active, config_legal;
  wire logic [7:0]   haddr;
  wire logic [1:0]   htrans, grid_mode;
  wire logic [2:0]   hsize, grid_window_code;
  wire logic [31:0]  hwdata, hrdata;
  wire logic [3:0]   poll_period_code, active_window_code;
  wire logic [13:0]  autoscale_group;
  int                n_errors = 0;
  int                n_checks = 0;
  // mirror of writable registers, index is byte offset over four
  logic [31:0] mir [0:9] = '{default: 32'h0};
  logic [31:0] msk [0:9] = '{32'hFFFFFFFF, 32'h1F, 32'hFFFFFF, 32'hFFFFFF, 32'hFFFFFF,
                             32'hFFFFFF, 32'hFFFFFF, 32'hFFFFFFFF, 32'hFFFFFF, 32'h3};
  // legal 5x5 baseline, then one-register variations and the verdict each should give;
  // longest poll period and shortest windows leave the most room in the period budget
  logic [31:0] bl [0:9] = '{32'h1E, 32'h10, 32'h7DF0, 32'h0, 32'h1F0,
                            32'h489240, 32'h12, 32'h0, 32'h0, 32'h3};
  int          ti [0:11] = '{9, 2, 3, 4, 6, 5, 5, 5, 1, 1, 1, 0};
  logic [31:0] tv [0:11] = '{32'h2, 32'h3DF0, 32'h10, 32'h5F0, 32'hA, 32'h5092C0,
                             32'h4C9280, 32'h509280, 32'h18, 32'h8, 32'h0, 32'h40000};
  logic        te [0:11] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 1, 0};
  always #10 hclk = ~hclk;
  ssc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .poll_period_code(poll_period_code), .active_window_code(active_window_code),
    .grid_window_code(grid_window_code), .grid_mode(grid_mode),
    .poll_enable(poll_enable), .clean_sampling_active(clean_sampling_active),
    .autoscale_group(autoscale_group), .config_legal(config_legal));
  ssc_host m (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  // ==========================================================
  // expectation helpers
  function automatic logic [13:0] exp_scale();
    logic [41:0] c;
    c = {mir[6][17:0], mir[5][23:0]};
    exp_scale = 14'h0;
    for (int g = 0; g < 14; g++)
      exp_scale[g] = (mir[6][22:21] != 2'h3) && !mir[9][0] && c[3 * g + 2];
  endfunction
  function automatic logic exp_clean();
    exp_clean = (mir[8][23:0] != 0) && (mir[2][23:0] != 0 || mir[0][16]);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    logic [31:0] q;
    m.xfer(8'(4 * i), 1'b1, d, q);
    mir[i] = d & msk[i];
  endtask
  task automatic rd_chk(input int i, input logic [31:0] e);
    logic [31:0] q;
    m.xfer(8'(4 * i), 1'b0, 32'h0, q);
    chk("read", q, e);
  endtask
  task automatic chk_out;
    chk("period", 32'(poll_period_code), 32'(mir[0][4:1]));
    chk("active", 32'(active_window_code), 32'(mir[0][8:5]));
    chk("grid window", 32'(grid_window_code), 32'(mir[1][2:0]));
    chk("grid mode", 32'(grid_mode), 32'(mir[1][4:3]));
    chk("poll", 32'(poll_enable), 32'(mir[9][0]));
    chk("clean", 32'(clean_sampling_active), 32'(exp_clean()));
    chk("scale", 32'(autoscale_group), 32'(exp_scale()));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under a few thousand cycles
  initial begin
    #400000;
    n_errors++;
    results;
  end
  // ==========================================================
  // main sequence
  initial begin
    int s;
    logic [31:0] d;
    logic [31:0] q;
    s = $urandom(62209);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, with writes to read-only and unmapped places ignored
    chk("legal", 32'(config_legal), 32'h1);
    m.xfer(8'h28, 1'b1, 32'hFFFFFFFF, q);
    m.xfer(8'h30, 1'b1, 32'hFFFFFFFF, q);
    for (int i = 0; i < 13; i++) begin
      m.xfer(8'(4 * i), 1'b0, 32'h0, q);
      chk("reset read", q, (i == 10) ? 32'h2F : 32'h0);
    end
    chk_out;
    $display("test reset done");
    // random writes, read straight back, settings compared
    for (int k = 0; k < 60; k++) begin
      s = $urandom % 10;
      d = ($urandom % 4 == 0) ? 32'h0 : $urandom;
      wr(s, d);
      rd_chk(s, mir[s]);
      rd_chk(11, 32'(exp_scale()));
      chk_out;
    end
    $display("test random done");
    // legality of grid, pairing, thermal and diagnostic settings
    for (int i = 0; i < 10; i++)
      wr(i, bl[i]);
    rd_chk(1, bl[1]);
    chk("legal base", 32'(config_legal), 32'h1);
    for (int t = 0; t < 12; t++) begin
      wr(ti[t], tv[t]);
      rd_chk(ti[t], mir[ti[t]]);
      chk("legal", 32'(config_legal), 32'(te[t]));
      chk_out;
      wr(ti[t], bl[ti[t]]);
    end
    $display("test legality done");
    // several registers at once: 6x6 grid with diagnostics, then 4x4 ignoring the fourth pair
    wr(2, 32'hFFF1);
    wr(3, 32'hF);
    wr(4, 32'h3FC);
    wr(0, 32'h4001E);
    wr(1, 32'h18);
    rd_chk(1, 32'h18);
    chk("legal 6x6", 32'(config_legal), 32'h1);
    wr(4, 32'h3FD);
    rd_chk(4, 32'h3FD);
    chk("legal cs diag", 32'(config_legal), 32'h0);
    wr(4, 32'h3FC);
    wr(3, 32'hE);
    rd_chk(3, 32'hE);
    chk("legal adc diag", 32'(config_legal), 32'h0);
    wr(3, 32'hF);
    wr(1, 32'h8);
    wr(6, 32'hA);
    rd_chk(6, 32'hA);
    chk("legal 4x4", 32'(config_legal), 32'h1);
    chk_out;
    $display("test multi done");
    // clean sampling source and autoscale code boundary
    wr(2, 32'h0);
    wr(8, 32'h1);
    wr(9, 32'h0);
    wr(5, 32'h8E38E3);
    rd_chk(11, 32'(exp_scale()));
    chk_out;
    wr(0, 32'h10000);
    rd_chk(0, 32'h10000);
    chk_out;
    $display("test corners done");
    results;
  end
endmodule
`default_nettype wire
